/* bench/tb_system_uart_line_config_regs.sv */
// self-checking bench for the config register bank
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin err_count++; \
  $display("unexpected %s expected %h seen %h", nm, e, g); end end
module tb_system_uart_line_config_regs import sulcr_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic srst_i, reg_wr_i, reg_rd_i, line_present_i, temp_fault_i, vbat_low_i;
  logic uart_rx_busy_i, gauge_reset_done_i, gauge_auto_on_i, reset_evt_i;
  logic line_uart_enter_i, line_uart_exit_i, line_tx_sw_i, line_rx_sw_i;
  logic uart_tx_done_i, chg_fsm_start_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
  logic [2:0] thermistor_enable_field_i, reset_code_i;
  logic gauge_reset_o, gauge_on_o, temp_hard_reset_o, uart_mode_o, uart_tx_sw_o;
  logic uart_rx_sw_o, uart_tmo_timer_en_o, line_wake_o, low_power_o, current_double_o;
  logic chg_reinit_o, sys_ldo_en_o;
  logic [1:0] undervoltage_threshold_sel_o, line_sink_current_sel_o;
  logic [1:0] line_pulse_threshold_sel_o;
  int err_count = 0;
  int n_checks = 0;
  sulcr_byte_t rdv;

  ////////////////////////////////////////////////////////////////////////////
  // clock and device
  always #20 clk_i = ~clk_i;

  sulcr_top u_dut (
    .clk_i(clk_i), .srst_i(srst_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .line_present_i(line_present_i), .temp_fault_i(temp_fault_i), .vbat_low_i(vbat_low_i),
    .uart_rx_busy_i(uart_rx_busy_i), .gauge_reset_done_i(gauge_reset_done_i),
    .gauge_auto_on_i(gauge_auto_on_i), .thermistor_enable_field_i(thermistor_enable_field_i),
    .reset_evt_i(reset_evt_i), .reset_code_i(reset_code_i),
    .line_uart_enter_i(line_uart_enter_i), .line_uart_exit_i(line_uart_exit_i),
    .line_tx_sw_i(line_tx_sw_i), .line_rx_sw_i(line_rx_sw_i),
    .uart_tx_done_i(uart_tx_done_i), .chg_fsm_start_i(chg_fsm_start_i),
    .gauge_reset_o(gauge_reset_o), .gauge_on_o(gauge_on_o),
    .temp_hard_reset_o(temp_hard_reset_o), .uart_mode_o(uart_mode_o),
    .uart_tx_sw_o(uart_tx_sw_o), .uart_rx_sw_o(uart_rx_sw_o),
    .uart_tmo_timer_en_o(uart_tmo_timer_en_o), .line_wake_o(line_wake_o),
    .low_power_o(low_power_o), .current_double_o(current_double_o),
    .chg_reinit_o(chg_reinit_o), .sys_ldo_en_o(sys_ldo_en_o),
    .undervoltage_threshold_sel_o(undervoltage_threshold_sel_o),
    .line_sink_current_sel_o(line_sink_current_sel_o),
    .line_pulse_threshold_sel_o(line_pulse_threshold_sel_o)
  );

  ////////////////////////////////////////////////////////////////////////////
  // access helpers, all driven on the falling edge
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk_i);
  endtask : wait_n

  task automatic wr(input sulcr_byte_t a, input sulcr_byte_t d);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input sulcr_byte_t a);
    @(negedge clk_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    rdv = reg_rdata_o;
  endtask : rd

  task automatic do_reset();
    @(negedge clk_i);
    srst_i = 1'b1;
    wait_n(6);
    srst_i = 1'b0;
  endtask : do_reset

  task automatic end_of_test();
    if (err_count == 0 && n_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : end_of_test

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic t_regs();
    sulcr_byte_t offs[6] = '{8'h1b, 8'h1c, 8'h20, 8'h21, 8'h30, 8'h31};
    sulcr_byte_t rstv[6] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'hc4, 8'h41};
    sulcr_byte_t msk[6] = '{8'h61, 8'h00, 8'h07, 8'h7f, 8'hdf, 8'hc3};
    for (int i = 0; i < 6; i++) begin
      rd(offs[i]);
      `CHK("reset value", rstv[i], rdv)
      // all ones, but no self-clearing gauge reset request
      wr(offs[i], (i == 0) ? 8'h7f : 8'hff);
      rd(offs[i]);
      `CHK("written ones", msk[i], rdv)
      wr(offs[i], 8'h00);
      rd(offs[i]);
      `CHK("written zeros", 8'h00, rdv)
    end
    wr(8'h22, 8'hff);
    rd(8'h22);
    `CHK("unmapped", 8'h00, rdv)
  endtask : t_regs

  task automatic t_gauge();
    do_reset();
    wr(8'h1b, 8'h80);
    `CHK("gauge reset set", 1'b1, gauge_reset_o)
    wait_n(3);
    `CHK("gauge reset held", 1'b1, gauge_reset_o)
    gauge_reset_done_i = 1'b1;
    wait_n(1);
    gauge_reset_done_i = 1'b0;
    rd(8'h1b);
    `CHK("gauge reset cleared", 8'h00, rdv)
    `CHK("gauge reset pin", 1'b0, gauge_reset_o)
    gauge_auto_on_i = 1'b1;
    wr(8'h1b, 8'h40);
    `CHK("gauge forced off", 1'b0, gauge_on_o)
    wr(8'h1b, 8'h60);
    gauge_auto_on_i = 1'b0;
    wait_n(1);
    `CHK("gauge forced on", 1'b1, gauge_on_o)
    wr(8'h1b, 8'h20);
    `CHK("gauge value ignored", 1'b0, gauge_on_o)
    gauge_auto_on_i = 1'b1;
    wait_n(1);
    `CHK("gauge follows auto", 1'b1, gauge_on_o)
    gauge_auto_on_i = 1'b0;
    wr(8'h1b, 8'h01);
    thermistor_enable_field_i = 3'h4;
    temp_fault_i = 1'b1;
    wait_n(6);
    `CHK("temp hard reset", 1'b1, temp_hard_reset_o)
    thermistor_enable_field_i = 3'h3;
    wait_n(1);
    `CHK("thermistor at limit", 1'b0, temp_hard_reset_o)
    thermistor_enable_field_i = 3'h7;
    line_present_i = 1'b1;
    wait_n(6);
    `CHK("line supply present", 1'b0, temp_hard_reset_o)
    line_present_i = 1'b0;
    wr(8'h1b, 8'h00);
    wait_n(6);
    `CHK("hard reset disabled", 1'b0, temp_hard_reset_o)
    temp_fault_i = 1'b0;
  endtask : t_gauge

  task automatic t_cause();
    for (int c = 1; c <= 4; c++) begin
      reset_code_i = 3'(c);
      reset_evt_i = 1'b1;
      wait_n(1);
      reset_evt_i = 1'b0;
      rd(8'h1c);
      `CHK("reset cause", {3'(c), 5'h00}, rdv)
    end
  endtask : t_cause

  task automatic t_mode();
    do_reset();
    wr(8'h21, 8'h70);
    `CHK("register enter", 1'b1, uart_mode_o)
    wr(8'h21, 8'h78);
    `CHK("register abort", 1'b0, uart_mode_o)
    wr(8'h21, 8'h50);
    `CHK("line source no command", 1'b0, uart_mode_o)
    line_uart_enter_i = 1'b1;
    wait_n(1);
    line_uart_enter_i = 1'b0;
    wait_n(1);
    `CHK("line enter", 1'b1, uart_mode_o)
    line_uart_exit_i = 1'b1;
    wait_n(1);
    line_uart_exit_i = 1'b0;
    wait_n(1);
    `CHK("line exit", 1'b0, uart_mode_o)
    for (int k = 0; k < 4; k++) begin
      wr(8'h44 | 8'(k), 8'h00);
      wr(8'h21, 8'h44 | 8'(k));
      `CHK("tx switch reg", k[1], uart_tx_sw_o)
      `CHK("rx switch reg", k[0], uart_rx_sw_o)
      line_tx_sw_i = ~k[0];
      line_rx_sw_i = k[1];
      wr(8'h21, 8'h40 | 8'(k));
      `CHK("tx switch line", ~k[0], uart_tx_sw_o)
      `CHK("rx switch line", k[1], uart_rx_sw_o)
    end
    line_tx_sw_i = 1'b0;
    line_rx_sw_i = 1'b0;
  endtask : t_mode

  task automatic t_turn();
    int lim[4] = '{200, 800, 1600, 3200};
    int cnt;
    do_reset();
    wr(8'h21, 8'h70);
    for (int c = 0; c < 4; c++) begin
      wr(8'h20, 8'h00);
      wr(8'h20, 8'h04 | 8'(c));
      cnt = 0;
      while (uart_tx_sw_o !== 1'b1) begin
        @(negedge clk_i);
        cnt++;
        uart_rx_busy_i = (c == 1 && cnt >= 400 && cnt < 402);
        if (cnt > 4000) begin
          err_count++;
          end_of_test();
        end
      end
      if (c == 1) begin
        `CHK("idle restart", 1'b1, cnt >= lim[c] + 400 && cnt <= lim[c] + 412)
      end else begin
        `CHK("turnaround time", 1'b1, cnt >= lim[c] - 2 && cnt <= lim[c] + 6)
      end
      uart_tx_done_i = 1'b1;
      wait_n(1);
      uart_tx_done_i = 1'b0;
      wait_n(1);
      `CHK("back to receive", 1'b0, uart_tx_sw_o)
    end
    wr(8'h21, 8'h40);
    wr(8'h20, 8'h04);
    wait_n(260);
    `CHK("no turnaround out of mode", 1'b0, uart_tx_sw_o)
  endtask : t_turn

  task automatic t_power();
    do_reset();
    vbat_low_i = 1'b1;
    wait_n(6);
    `CHK("charger wake", 1'b1, line_wake_o)
    `CHK("low power default", 1'b1, low_power_o)
    `CHK("ldo default", 1'b1, sys_ldo_en_o)
    wr(8'h30, 8'h18);
    `CHK("wake disabled", 1'b0, line_wake_o)
    `CHK("current double", 1'b1, current_double_o)
    `CHK("ldo off", 1'b0, sys_ldo_en_o)
    `CHK("low power off", 1'b0, low_power_o)
    `CHK("reinit idle", 1'b0, chg_reinit_o)
    chg_fsm_start_i = 1'b1;
    wait_n(1);
    `CHK("reinit on start", 1'b1, chg_reinit_o)
    wr(8'h30, 8'h10);
    `CHK("reinit disabled", 1'b0, chg_reinit_o)
    chg_fsm_start_i = 1'b0;
    vbat_low_i = 1'b0;
    for (int k = 0; k < 4; k++) begin
      wr(8'h30, 8'(k));
      wr(8'h31, {2'(k), 4'h0, 2'(3 - k)});
      `CHK("undervoltage sel", 2'(k), undervoltage_threshold_sel_o)
      `CHK("sink sel", 2'(k), line_sink_current_sel_o)
      `CHK("pulse sel", 2'(3 - k), line_pulse_threshold_sel_o)
    end
  endtask : t_power

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    {srst_i, reg_wr_i, reg_rd_i, line_present_i, temp_fault_i, vbat_low_i} = 6'h20;
    {uart_rx_busy_i, gauge_reset_done_i, gauge_auto_on_i, reset_evt_i} = 4'h0;
    {line_uart_enter_i, line_uart_exit_i, line_tx_sw_i, line_rx_sw_i} = 4'h0;
    {uart_tx_done_i, chg_fsm_start_i} = 2'h0;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    thermistor_enable_field_i = 3'h0;
    reset_code_i = 3'h0;
    wait_n(6);
    srst_i = 1'b0;
    t_regs();
    t_gauge();
    t_cause();
    t_mode();
    t_turn();
    t_power();
    end_of_test();
  end
endmodule : tb_system_uart_line_config_regs

/* rtl/sulcr_cfg.svh */
// register offsets, field positions, reset values and timing counts of the config bank
// Function
// - Writing one to gauge reset bit resets gauge; bit self-clears when done.
// - Override bit set: gauge follows manual value bit; clear: value ignored.
// - Temperature fault, no line supply, enable set, thermistor field above 3: hard reset.
// - Read-only three-bit field holds last reset cause since power-up.
// - Auto switching turns receive to transmit after 8/32/64/128 us idle.
// - Mode-source bit picks line commands (0) or register writes (1) for UART mode.
// - Under register control, enter bit one puts device in UART mode.
// - Under register control, abort bit one aborts UART mode.
// - Switch-source bit picks line logic (0) or register bits (1) for switches.
// - Under register control, switch bits close (1) or open (0) each switch.
// - Wakeup bit one lets low battery wake the line state machine.
// - Current-double bit doubles line limit and charge current; LDO limit unchanged.
// - Re-init bit one restores charger registers whenever charger machine starts.
// - System LDO enable bit switches LDO; resets to one.
// - Two-bit field selects undervoltage threshold 2.7/2.9/3.0/3.2 V.
// - Two-bit field selects sink current 50.3/70.4/90.4/110.5 mA.
// - Two-bit field selects pulse threshold 75/90/105/120 mV.
// - Low-power enable bit switches low-power operation; resets to one.
`ifndef SULCR_CFG_SVH
`define SULCR_CFG_SVH

////////////////////////////////////////////////////////////////////////////////
// offsets
`define SULCR_OFS_BOOT_CMD 8'h1b
`define SULCR_OFS_LAST_RST 8'h1c
`define SULCR_OFS_TURN_CTL 8'h20
`define SULCR_OFS_MODE_CTL 8'h21
`define SULCR_OFS_SYS_CFG 8'h30
`define SULCR_OFS_LINE_TX 8'h31

////////////////////////////////////////////////////////////////////////////////
// writable masks and reset values
`define SULCR_MSK_BOOT_CMD 8'he1
`define SULCR_MSK_TURN_CTL 8'h07
`define SULCR_MSK_MODE_CTL 8'h7f
`define SULCR_MSK_SYS_CFG 8'hdf
`define SULCR_MSK_LINE_TX 8'hc3
`define SULCR_RST_BOOT_CMD 8'h00
`define SULCR_RST_TURN_CTL 8'h00
`define SULCR_RST_MODE_CTL 8'h40
`define SULCR_RST_SYS_CFG 8'hc4
`define SULCR_RST_LINE_TX 8'h41

////////////////////////////////////////////////////////////////////////////////
// field positions
`define SULCR_B_GAUGE_RST 7
`define SULCR_B_GAUGE_OVR 6
`define SULCR_B_GAUGE_VAL 5
`define SULCR_B_TEMP_HRST 0
`define SULCR_B_RST_LO 5
`define SULCR_B_AUTO_EN 2
`define SULCR_B_TMO_LO 0
`define SULCR_B_TMO_TMR 6
`define SULCR_B_MODE_SRC 5
`define SULCR_B_MODE_ENT 4
`define SULCR_B_MODE_ABR 3
`define SULCR_B_SW_SRC 2
`define SULCR_B_TX_SW 1
`define SULCR_B_RX_SW 0
`define SULCR_B_CHG_WAKE 7
`define SULCR_B_LOW_PWR 6
`define SULCR_B_CUR_X2 4
`define SULCR_B_CHG_INIT 3
`define SULCR_B_LDO_EN 2
`define SULCR_B_UVLO_LO 0
`define SULCR_B_SINK_LO 6
`define SULCR_B_THR_LO 0
`define SULCR_THM_LIMIT 3

////////////////////////////////////////////////////////////////////////////////
// turnaround timeouts
`define SULCR_CLK_MHZ 25
`define SULCR_TMO0_US 8
`define SULCR_TMO1_US 32
`define SULCR_TMO2_US 64
`define SULCR_TMO3_US 128
`define SULCR_TMO0_CYC (`SULCR_TMO0_US * `SULCR_CLK_MHZ)
`define SULCR_TMO1_CYC (`SULCR_TMO1_US * `SULCR_CLK_MHZ)
`define SULCR_TMO2_CYC (`SULCR_TMO2_US * `SULCR_CLK_MHZ)
`define SULCR_TMO3_CYC (`SULCR_TMO3_US * `SULCR_CLK_MHZ)

`endif

/* rtl/sulcr_pkg.sv */
// types of the config register bank
package sulcr_pkg;
  typedef enum logic {
    SULCR_DIR_RX,
    SULCR_DIR_TX
  } sulcr_dir_e;
  typedef enum logic [2:0] {
    SULCR_RST_NONE = 3'h0,
    SULCR_RST_SOFT = 3'h1,
    SULCR_RST_HARD = 3'h2,
    SULCR_RST_BOTH = 3'h3,
    SULCR_RST_BOOT = 3'h4
  } sulcr_rst_cause_e;
  typedef logic [7:0] sulcr_byte_t;
endpackage : sulcr_pkg

/* rtl/sulcr_top.sv */
// register bank for gauge, reset cause, uart turnaround and system configuration
`include "sulcr_cfg.svh"
module sulcr_top import sulcr_pkg::*; #(
  parameter int THM_W = 3,
  parameter int CNT_W = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // register access port
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // asynchronous sense inputs
  input wire logic line_present_i,
  input wire logic temp_fault_i,
  input wire logic vbat_low_i,
  input wire logic uart_rx_busy_i,
  // on-chip status and events
  input wire logic gauge_reset_done_i,
  input wire logic gauge_auto_on_i,
  input wire logic [THM_W-1:0] thermistor_enable_field_i,
  input wire logic reset_evt_i,
  input wire logic [2:0] reset_code_i,
  input wire logic line_uart_enter_i,
  input wire logic line_uart_exit_i,
  input wire logic line_tx_sw_i,
  input wire logic line_rx_sw_i,
  input wire logic uart_tx_done_i,
  input wire logic chg_fsm_start_i,
  // gauge and reset controls
  output logic gauge_reset_o,
  output logic gauge_on_o,
  output logic temp_hard_reset_o,
  // uart controls
  output logic uart_mode_o,
  output logic uart_tx_sw_o,
  output logic uart_rx_sw_o,
  output logic uart_tmo_timer_en_o,
  // power configuration
  output logic line_wake_o,
  output logic low_power_o,
  output logic current_double_o,
  output logic chg_reinit_o,
  output logic sys_ldo_en_o,
  output logic [1:0] undervoltage_threshold_sel_o,
  output logic [1:0] line_sink_current_sel_o,
  output logic [1:0] line_pulse_threshold_sel_o
);

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: change accepted once stages two and three agree
  localparam int NSYNC = 4;
  logic [NSYNC-1:0] pin_raw;
  logic [NSYNC-1:0] sync1_r;
  logic [NSYNC-1:0] sync2_r;
  logic [NSYNC-1:0] sync3_r;
  logic [NSYNC-1:0] pin_r;
  logic line_present;
  logic temp_fault;
  logic vbat_low;
  logic rx_busy;

  assign pin_raw = {uart_rx_busy_i, vbat_low_i, temp_fault_i, line_present_i};

  // three-stage chain, one per pin
  genvar gi;
  for (gi = 0; gi < NSYNC; gi++) begin : g_sync
    always_ff @(posedge clk_i) begin
      if (srst_i) begin
        sync1_r[gi] <= 1'b0;
        sync2_r[gi] <= 1'b0;
        sync3_r[gi] <= 1'b0;
        pin_r[gi] <= 1'b0;
      end else begin
        sync1_r[gi] <= pin_raw[gi];
        sync2_r[gi] <= sync1_r[gi];
        sync3_r[gi] <= sync2_r[gi];
        if (sync2_r[gi] == sync3_r[gi]) begin
          pin_r[gi] <= sync3_r[gi];
        end
      end
    end
  end

  assign {rx_busy, vbat_low, temp_fault, line_present} = pin_r;

  //////////////////////////////////////////////////////////////////////////////
  // register storage
  sulcr_byte_t boot_cmd_r;
  sulcr_byte_t turn_ctl_r;
  sulcr_byte_t mode_ctl_r;
  sulcr_byte_t sys_cfg_r;
  sulcr_byte_t line_tx_r;
  logic [2:0] rst_cause_r;
  logic wr_boot;

  assign wr_boot = reg_wr_i && (reg_addr_i == `SULCR_OFS_BOOT_CMD);

  // gauge command: write sets the reset request, done clears it, set wins
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      boot_cmd_r <= `SULCR_RST_BOOT_CMD;
    end else begin
      if (wr_boot) begin
        boot_cmd_r <= reg_wdata_i & `SULCR_MSK_BOOT_CMD;
      end
      if (gauge_reset_done_i
          && !(wr_boot && reg_wdata_i[`SULCR_B_GAUGE_RST])) begin
        boot_cmd_r[`SULCR_B_GAUGE_RST] <= 1'b0;
      end
    end
  end

  // plain read-write registers, unassigned bits masked off
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      turn_ctl_r <= `SULCR_RST_TURN_CTL;
      mode_ctl_r <= `SULCR_RST_MODE_CTL;
      sys_cfg_r <= `SULCR_RST_SYS_CFG;
      line_tx_r <= `SULCR_RST_LINE_TX;
    end else if (reg_wr_i) begin
      unique case (reg_addr_i)
        `SULCR_OFS_TURN_CTL: turn_ctl_r <= reg_wdata_i & `SULCR_MSK_TURN_CTL;
        `SULCR_OFS_MODE_CTL: mode_ctl_r <= reg_wdata_i & `SULCR_MSK_MODE_CTL;
        `SULCR_OFS_SYS_CFG: sys_cfg_r <= reg_wdata_i & `SULCR_MSK_SYS_CFG;
        `SULCR_OFS_LINE_TX: line_tx_r <= reg_wdata_i & `SULCR_MSK_LINE_TX;
        default: ;
      endcase
    end
  end

  // last reset cause, cleared only by power-up reset
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rst_cause_r <= SULCR_RST_NONE;
    end else if (reset_evt_i) begin
      rst_cause_r <= reset_code_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // read port
  sulcr_byte_t rd_nxt;

  // readback mux, unmapped offsets read zero
  always_comb begin
    unique case (reg_addr_i)
      `SULCR_OFS_BOOT_CMD: rd_nxt = boot_cmd_r;
      `SULCR_OFS_LAST_RST: rd_nxt = {rst_cause_r, 5'h00};
      `SULCR_OFS_TURN_CTL: rd_nxt = turn_ctl_r;
      `SULCR_OFS_MODE_CTL: rd_nxt = mode_ctl_r;
      `SULCR_OFS_SYS_CFG: rd_nxt = sys_cfg_r;
      `SULCR_OFS_LINE_TX: rd_nxt = line_tx_r;
      default: rd_nxt = 8'h00;
    endcase
  end

  // read data held until the next read
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      reg_rdata_o <= rd_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // gauge and temperature reset
  assign gauge_reset_o = boot_cmd_r[`SULCR_B_GAUGE_RST];
  assign gauge_on_o = boot_cmd_r[`SULCR_B_GAUGE_OVR] ? boot_cmd_r[`SULCR_B_GAUGE_VAL]
                    : gauge_auto_on_i;
  assign temp_hard_reset_o = boot_cmd_r[`SULCR_B_TEMP_HRST] && !line_present && temp_fault
      && (thermistor_enable_field_i > THM_W'(`SULCR_THM_LIMIT));

  //////////////////////////////////////////////////////////////////////////////
  // uart mode
  logic line_mode_r;
  logic reg_mode;

  // line-commanded mode follows enter and exit events
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      line_mode_r <= 1'b0;
    end else if (line_uart_exit_i) begin
      line_mode_r <= 1'b0;
    end else if (line_uart_enter_i) begin
      line_mode_r <= 1'b1;
    end
  end

  assign reg_mode = mode_ctl_r[`SULCR_B_MODE_ENT]
                  && !mode_ctl_r[`SULCR_B_MODE_ABR];
  assign uart_mode_o = mode_ctl_r[`SULCR_B_MODE_SRC] ? reg_mode : line_mode_r;
  assign uart_tmo_timer_en_o = mode_ctl_r[`SULCR_B_TMO_TMR];

  //////////////////////////////////////////////////////////////////////////////
  // automatic turnaround
  sulcr_dir_e dir_r;
  logic auto_on;
  logic turn_fire;
  logic [CNT_W-1:0] turn_limit;

  assign auto_on = turn_ctl_r[`SULCR_B_AUTO_EN] && uart_mode_o;

  // timeout code to cycles
  always_comb begin
    unique case (turn_ctl_r[`SULCR_B_TMO_LO +: 2])
      2'h0: turn_limit = CNT_W'(`SULCR_TMO0_CYC);
      2'h1: turn_limit = CNT_W'(`SULCR_TMO1_CYC);
      2'h2: turn_limit = CNT_W'(`SULCR_TMO2_CYC);
      2'h3: turn_limit = CNT_W'(`SULCR_TMO3_CYC);
    endcase
  end

  sulcr_turn_timer #(
    .CNT_W(CNT_W)
  ) u_turn_timer (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .run_i(auto_on && (dir_r == SULCR_DIR_RX) && !rx_busy),
    .limit_i(turn_limit),
    .fire_o(turn_fire)
  );

  // direction: receive until idle timeout, back after transmit done
  always_ff @(posedge clk_i) begin
    if (srst_i || !auto_on) begin
      dir_r <= SULCR_DIR_RX;
    end else begin
      unique case (dir_r)
        SULCR_DIR_RX: if (turn_fire) dir_r <= SULCR_DIR_TX;
        SULCR_DIR_TX: if (uart_tx_done_i) dir_r <= SULCR_DIR_RX;
      endcase
    end
  end

  // switch source: register bits or line logic / auto direction
  always_comb begin
    if (mode_ctl_r[`SULCR_B_SW_SRC]) begin
      uart_tx_sw_o = mode_ctl_r[`SULCR_B_TX_SW];
      uart_rx_sw_o = mode_ctl_r[`SULCR_B_RX_SW];
    end else if (auto_on) begin
      uart_tx_sw_o = (dir_r == SULCR_DIR_TX);
      uart_rx_sw_o = (dir_r == SULCR_DIR_RX);
    end else begin
      uart_tx_sw_o = line_tx_sw_i;
      uart_rx_sw_o = line_rx_sw_i;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // system and line configuration
  assign line_wake_o = sys_cfg_r[`SULCR_B_CHG_WAKE] && vbat_low;
  assign low_power_o = sys_cfg_r[`SULCR_B_LOW_PWR];
  assign current_double_o = sys_cfg_r[`SULCR_B_CUR_X2];
  assign chg_reinit_o = sys_cfg_r[`SULCR_B_CHG_INIT] && chg_fsm_start_i;
  assign sys_ldo_en_o = sys_cfg_r[`SULCR_B_LDO_EN];
  assign undervoltage_threshold_sel_o = sys_cfg_r[`SULCR_B_UVLO_LO +: 2];
  assign line_sink_current_sel_o = line_tx_r[`SULCR_B_SINK_LO +: 2];
  assign line_pulse_threshold_sel_o = line_tx_r[`SULCR_B_THR_LO +: 2];

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  property p_gauge_clear;
    gauge_reset_o && gauge_reset_done_i && !wr_boot |=> !gauge_reset_o;
  endproperty
  a_gauge_clear: assert property (p_gauge_clear) else $error("gauge reset not cleared");

  property p_gauge_set;
    wr_boot && reg_wdata_i[`SULCR_B_GAUGE_RST] |=> gauge_reset_o;
  endproperty
  a_gauge_set: assert property (p_gauge_set) else $error("gauge reset not set");

  property p_gauge_on;
    boot_cmd_r[`SULCR_B_GAUGE_OVR] |-> gauge_on_o == boot_cmd_r[`SULCR_B_GAUGE_VAL];
  endproperty
  a_gauge_on: assert property (p_gauge_on) else $error("gauge override ignored");

  property p_temp_line;
    line_present |-> !temp_hard_reset_o;
  endproperty
  a_temp_line: assert property (p_temp_line) else $error("hard reset with line");

  property p_cause;
    reset_evt_i |=> rst_cause_r == $past(reset_code_i);
  endproperty
  a_cause: assert property (p_cause) else $error("reset cause wrong");

  property p_turn;
    auto_on && dir_r == SULCR_DIR_RX && turn_fire |=> uart_tx_sw_o
      || mode_ctl_r[`SULCR_B_SW_SRC] || !auto_on;
  endproperty
  a_turn: assert property (p_turn) else $error("turnaround missed");

  property p_turn_early;
    auto_on && !rx_busy && dir_r == SULCR_DIR_RX && turn_ctl_r[1:0] == 2'h0
      && !$past(auto_on && !rx_busy && dir_r == SULCR_DIR_RX)
      ##1 (auto_on && !rx_busy && $stable(turn_ctl_r))[*8] |-> dir_r == SULCR_DIR_RX;
  endproperty
  a_turn_early: assert property (p_turn_early) else $error("turnaround too early");

  property p_abort;
    mode_ctl_r[`SULCR_B_MODE_SRC] && mode_ctl_r[`SULCR_B_MODE_ABR] |-> !uart_mode_o;
  endproperty
  a_abort: assert property (p_abort) else $error("abort ignored");

  property p_line_mode;
    !mode_ctl_r[`SULCR_B_MODE_SRC] && $past(line_uart_enter_i) && !$past(line_uart_exit_i)
      |-> uart_mode_o;
  endproperty
  a_line_mode: assert property (p_line_mode) else $error("line enter ignored");

  property p_switch;
    mode_ctl_r[`SULCR_B_SW_SRC] |-> uart_tx_sw_o == mode_ctl_r[`SULCR_B_TX_SW]
      && uart_rx_sw_o == mode_ctl_r[`SULCR_B_RX_SW];
  endproperty
  a_switch: assert property (p_switch) else $error("switch bits ignored");

  property p_reserved;
    reg_wr_i && reg_addr_i == `SULCR_OFS_TURN_CTL |=> turn_ctl_r[7:3] == 5'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits stored");

  c_gauge_reset: cover property (wr_boot ##[1:20] gauge_reset_done_i);
  c_turn: cover property (auto_on && turn_fire ##[1:50] uart_tx_done_i);
  c_temp: cover property (temp_hard_reset_o);
  c_reg_mode: cover property (mode_ctl_r[`SULCR_B_MODE_SRC] && uart_mode_o);
endmodule : sulcr_top

/* rtl/sulcr_turn_timer.sv */
// idle timer that fires once after a selectable number of cycles
module sulcr_turn_timer #(
  parameter int CNT_W = 12
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic srst_i,
  // control
  input wire logic run_i,
  input wire logic [CNT_W-1:0] limit_i,
  // event
  output logic fire_o
);
  logic [CNT_W-1:0] cnt_r;

  // count idle cycles, saturate at the limit, clear when stopped
  always_ff @(posedge clk_i) begin
    if (srst_i || !run_i) begin
      cnt_r <= '0;
    end else if (cnt_r != limit_i) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end

  // one pulse in the cycle the last idle cycle is counted
  assign fire_o = run_i && (cnt_r == limit_i - 1'b1);
endmodule : sulcr_turn_timer
